// ---- rtl/dtc_timers.sv ----
/*
 * Two 16-bit timer/counters with PWM, auto-reload, split and clock-out
 * operation, behind an APB slave.
 * Assumes pins and APB signals synchronous to clk (10 MHz).
 */
// The implementer's own choices: the register addresses and the APB slave port.
// Behaviour
// [R1] timer advances every 12 clocks, or every clock with fast select
// [R2] timer 0 also offers clock divided by 48 and by 192
// [R3] counter samples its pin per timer-rate cycle, counts high-then-low
// [R4] counted edge shows in count the cycle after detection
// [R5] mode 0 is PWM; all-ones to zero wrap sets overflow flag
// [R6] counting needs run bit and gate off or interrupt input high
// [R7] mode 1 is a full 16-bit timer or counter, same qualification
// [R8] mode 2: low byte overflow sets flag, reloads from high byte
// [R9] timer 1 in mode 3 holds its count
// [R10] timer 0 mode 3 low byte uses timer 0 controls and flag
// [R11] timer 0 mode 3 high byte: internal clock, timer 1 run and flag
// [R12] clock-out: 8-bit reload, overflow toggles a 50% duty output
// [R13] timer 0 clock-out drives P3.4, timer 1 drives P3.5
// [R14] timer 1 clock-out counts only clock/12 or clock
// [R15] timer 0 clock-out rate is clock over n*(256-reload), n 24/2/96/384
// [R16] timer 1 clock-out rate is clock over n*(256-reload), n 24 or 2
// [R17] clock-out overflow sets flag but raises no interrupt
// [R18] software sets source, enable, clears C/T, loads bytes, then runs
// [R19] timer 1 overflow serves baud rate and clock-out together
// [R20] mode field: PWM, 16-bit, 8-bit reload, split or stopped
// [R21] timer 0 source decoded from extra prescale, fast and C/T bits
// [R22] everything resets to zero; timers stay stopped until run set

`include "dtc_consts.svh"

// one timer core: two count bytes and their mode handling
module dtc_unit (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // count enables and mode
  input wire logic lo_en,
  input wire logic hi_en,
  input wire logic ar_force,
  input dtc_pkg::dtc_mode_t mode,
  // software writes
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [7:0] wdata,
  // state and events
  output logic [7:0] lo_r,
  output logic [7:0] hi_r,
  output logic ovf,
  output logic hi_ovf,
  output logic pwm_r
);
  import dtc_pkg::*;
  dtc_mode_t m;
  logic wrap;

  // clock-out overrides the mode field with 8-bit reload
  assign m = ar_force ? DTC_RELOAD : mode; // [R12]
  assign wrap = (lo_r == 8'hff);

  // unit overflow: 8-bit wrap, or 16-bit wrap in wide mode
  always_comb begin
    ovf = lo_en && wrap && (m != DTC_WIDE || hi_r == 8'hff); // [R5] [R7]
    hi_ovf = hi_en && (m == DTC_SPLIT) && (hi_r == 8'hff); // [R11]
  end

  // low byte; a software write beats a count in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lo_r <= `DTC_RST_BYTE; // [R22]
    end else if (wr_lo) begin
      lo_r <= wdata;
    end else if (lo_en) begin
      if (m == DTC_RELOAD && wrap) begin
        lo_r <= hi_r; // [R8] [R12]
      end else begin
        lo_r <= lo_r + 8'h01; // [R4]
      end
    end
  end

  // high byte: carry in wide mode, own count in split mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hi_r <= `DTC_RST_BYTE; // [R22]
    end else if (wr_hi) begin
      hi_r <= wdata;
    end else if (m == DTC_WIDE && lo_en && wrap) begin
      hi_r <= hi_r + 8'h01; // [R7]
    end else if (m == DTC_SPLIT && hi_en) begin
      hi_r <= hi_r + 8'h01; // [R11]
    end
  end

  // pwm level: high while the count is below the high byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_r <= 1'b0;
    end else begin
      pwm_r <= (m == DTC_PWM) && (lo_r < hi_r); // [R5]
    end
  end
endmodule

// top: APB registers, prescaler, source select, flags, clock-out pins
module dtc_timers (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // count and gate inputs
  input wire logic t0_pin,
  input wire logic t1_pin,
  input wire logic ext_int0,
  input wire logic ext_int1,
  // other clock sources, one-cycle pulses
  input wire logic ilrc_tick,
  input wire logic wdt_tick,
  // interrupt requests and baud source
  output logic t0_irq,
  output logic t1_irq,
  output logic t1_baud_tick,
  // clock-out and pwm pins
  output logic p34_out,
  output logic p34_drive,
  output logic p35_out,
  output logic p35_drive,
  output logic pwm0_out,
  output logic pwm1_out
);
  import dtc_pkg::*;
  dtc_cfg_t cfg0_r, cfg1_r;
  logic tf0_r, tf1_r, tr0_r, tr1_r;
  logic xl_r, x12_0_r, x12_1_r, cko0_en_r, cko1_en_r;
  logic [3:0] div12_r, div16_r;
  logic tick12, tick48, tick192;
  logic samp0_r, samp1_r, pend0_r, pend1_r;
  logic acc, wr, hit;
  logic [2:0] sel0;
  logic [1:0] sel1;
  logic src0, src0_int, src1, run0, run1, t0_split;
  logic [7:0] tl0, th0, tl1, th1;
  logic ovf0, ovf0_hi, ovf1, ovf1_hi, pwm0, pwm1;
  logic irq0_r, irq1_r, baud_r, cko0_r, cko1_r;
  logic [31:0] rd;

  // apb: one wait state, so pready and prdata come from flops
  assign acc = psel && penable;
  assign wr = acc && pwrite && pready;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc && !pready;
      prdata <= (acc && !pready && !pwrite) ? rd : 32'h0000_0000;
      pslverr <= acc && !pready && !hit; // unmapped address
    end
  end

  // read mux; unused bits read as zero
  always_comb begin
    hit = 1'b1;
    rd = 32'h0000_0000;
    unique case (paddr)
      `DTC_OFS_CTRL: rd[7:4] = {tf1_r, tr1_r, tf0_r, tr0_r};
      `DTC_OFS_MODE: rd[7:0] = {cfg1_r, cfg0_r};
      `DTC_OFS_T0LO: rd[7:0] = tl0;
      `DTC_OFS_T1LO: rd[7:0] = tl1;
      `DTC_OFS_T0HI: rd[7:0] = th0;
      `DTC_OFS_T1HI: rd[7:0] = th1;
      `DTC_OFS_AUX: rd[4:0] = {xl_r, x12_1_r, x12_0_r, cko1_en_r, cko0_en_r};
      default: hit = 1'b0;
    endcase
  end

  // mode and auxiliary bits, plain software state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg0_r <= dtc_cfg_t'(`DTC_RST_BYTE); // [R22]
      cfg1_r <= dtc_cfg_t'(`DTC_RST_BYTE);
      {xl_r, x12_1_r, x12_0_r, cko1_en_r, cko0_en_r} <= 5'h00;
    end else if (wr && paddr == `DTC_OFS_MODE) begin
      {cfg1_r, cfg0_r} <= pwdata[7:0];
    end else if (wr && paddr == `DTC_OFS_AUX) begin
      xl_r <= pwdata[`DTC_AUX_TIMER0_EXTRA_PRESCALE];
      x12_1_r <= pwdata[`DTC_AUX_TIMER1_FAST_CLOCK_SELECT];
      x12_0_r <= pwdata[`DTC_AUX_TIMER0_FAST_CLOCK_SELECT];
      cko1_en_r <= pwdata[`DTC_AUX_T1CKOE];
      cko0_en_r <= pwdata[`DTC_AUX_T0CKOE];
    end
  end

  // run bits; software alone owns them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tr0_r <= 1'b0; // [R22]
      tr1_r <= 1'b0;
    end else if (wr && paddr == `DTC_OFS_CTRL) begin
      tr0_r <= pwdata[`DTC_CTRL_TR0];
      tr1_r <= pwdata[`DTC_CTRL_TR1];
    end
  end

  // prescaler: divide by 12, then 4 and 16 more for /48 and /192
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div12_r <= 4'h0;
      div16_r <= 4'h0;
    end else if (div12_r == `DTC_DIV12_LAST) begin
      div12_r <= 4'h0;
      div16_r <= div16_r + 4'h1;
    end else begin
      div12_r <= div12_r + 4'h1;
    end
  end

  assign tick12 = (div12_r == `DTC_DIV12_LAST); // [R1]
  assign tick48 = tick12 && (div16_r[1:0] == `DTC_DIV48_LAST); // [R2]
  assign tick192 = tick12 && (div16_r == `DTC_DIV192_LAST); // [R2]

  // pin sampling at the timer rate; a high-then-low pair is held
  // pending so the count moves on the following timer-rate cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      samp0_r <= 1'b0;
      samp1_r <= 1'b0;
      pend0_r <= 1'b0;
      pend1_r <= 1'b0;
    end else if (tick12) begin
      samp0_r <= t0_pin; // [R3]
      samp1_r <= t1_pin;
      pend0_r <= samp0_r && !t0_pin; // [R3]
      pend1_r <= samp1_r && !t1_pin;
    end
  end

  // clock-out forces timer mode regardless of the C/T bit
  assign sel0 = {xl_r, x12_0_r, cfg0_r.ct && !cko0_en_r};
  assign sel1 = {x12_1_r, cfg1_r.ct && !cko1_en_r}; // [R14]

  // timer 0 source decode; timer 1 overflow feeds code 111
  always_comb begin
    unique case (sel0)
      3'b000: src0 = tick12; // [R1] [R21]
      3'b001: src0 = tick12 && pend0_r; // [R4]
      3'b010: src0 = 1'b1;
      3'b011: src0 = ilrc_tick;
      3'b100: src0 = tick48; // [R2]
      3'b101: src0 = wdt_tick;
      3'b110: src0 = tick192;
      3'b111: src0 = ovf1;
    endcase
  end

  // high byte of split timer 0 never counts the pin
  assign src0_int = x12_0_r ? (xl_r ? tick192 : 1'b1)
    : (xl_r ? tick48 : tick12); // [R11]

  // timer 1 source decode
  assign src1 = sel1[1] ? (sel1[0] ? tick48 : 1'b1) // [R14]
    : (sel1[0] ? tick12 && pend1_r : tick12); // [R1] [R4]

  // run qualification; split timer 0 takes over timer 1's run bit,
  // so timer 1 then free-runs, its overflow setting no flag and raising no interrupt
  assign t0_split = (cfg0_r.mode == DTC_SPLIT) && !cko0_en_r;
  assign run0 = tr0_r && (!cfg0_r.gate || ext_int0); // [R6] [R10]
  assign run1 = t0_split ? 1'b1 : tr1_r && (!cfg1_r.gate || ext_int1);

  dtc_unit u_t0 (
    .clk(clk),
    .rst_b(rst_b),
    .lo_en(src0 && run0), // [R6] [R10]
    .hi_en(src0_int && tr1_r), // [R11]
    .ar_force(cko0_en_r), // [R12]
    .mode(cfg0_r.mode), // [R20]
    .wr_lo(wr && paddr == `DTC_OFS_T0LO),
    .wr_hi(wr && paddr == `DTC_OFS_T0HI),
    .wdata(pwdata[7:0]),
    .lo_r(tl0),
    .hi_r(th0),
    .ovf(ovf0),
    .hi_ovf(ovf0_hi),
    .pwm_r(pwm0)
  );

  // timer 1 in mode 3 gets no count enable unless clock-out is on
  dtc_unit u_t1 (
    .clk(clk),
    .rst_b(rst_b),
    .lo_en(src1 && run1 && (cfg1_r.mode != DTC_SPLIT || cko1_en_r)), // [R9]
    .hi_en(1'b0),
    .ar_force(cko1_en_r), // [R12]
    .mode(cfg1_r.mode), // [R20]
    .wr_lo(wr && paddr == `DTC_OFS_T1LO),
    .wr_hi(wr && paddr == `DTC_OFS_T1HI),
    .wdata(pwdata[7:0]),
    .lo_r(tl1),
    .hi_r(th1),
    .ovf(ovf1),
    .hi_ovf(ovf1_hi),
    .pwm_r(pwm1)
  );

  // overflow flags: hardware set wins over a software clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tf0_r <= 1'b0; // [R22]
      tf1_r <= 1'b0;
    end else begin
      if (ovf0) begin
        tf0_r <= 1'b1; // [R5] [R8] [R10] [R17]
      end else if (wr && paddr == `DTC_OFS_CTRL) begin
        tf0_r <= pwdata[`DTC_CTRL_TF0];
      end
      if (t0_split ? ovf0_hi : ovf1) begin
        tf1_r <= 1'b1; // [R11]
      end else if (wr && paddr == `DTC_OFS_CTRL) begin
        tf1_r <= pwdata[`DTC_CTRL_TF1];
      end
    end
  end

  // interrupt request pulses, suppressed in clock-out
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq0_r <= 1'b0;
      irq1_r <= 1'b0;
      baud_r <= 1'b0;
    end else begin
      irq0_r <= ovf0 && !cko0_en_r; // [R17]
      irq1_r <= t0_split ? ovf0_hi : ovf1 && !cko1_en_r; // [R11] [R17]
      baud_r <= ovf1; // [R19]
    end
  end

  // clock-out toggles: two overflows per output period give 50% duty
  // and the n*(256-reload) divide ratio
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cko0_r <= 1'b0;
      cko1_r <= 1'b0;
    end else begin
      if (!cko0_en_r) begin
        cko0_r <= 1'b0;
      end else if (ovf0) begin
        cko0_r <= !cko0_r; // [R12] [R15]
      end
      if (!cko1_en_r) begin
        cko1_r <= 1'b0;
      end else if (ovf1) begin
        cko1_r <= !cko1_r; // [R12] [R16] [R19]
      end
    end
  end

  // pins: every output straight from a flop
  assign t0_irq = irq0_r;
  assign t1_irq = irq1_r;
  assign t1_baud_tick = baud_r;
  assign p34_out = cko0_r; // [R13]
  assign p34_drive = cko0_en_r;
  assign p35_out = cko1_r; // [R13]
  assign p35_drive = cko1_en_r;
  assign pwm0_out = pwm0;
  assign pwm1_out = pwm1;

  // pin samples low after high at a timer-rate tick, per timer
  sequence pin_fall_s;
    tick12 && samp0_r && !t0_pin;
  endsequence
  sequence t1_fall_s;
    tick12 && samp1_r && !t1_pin;
  endsequence
  // the next timer-rate tick, twelve clocks on
  sequence next_tick_s;
    ##[1:12] tick12;
  endsequence
  prescale_period_a: assert property ( // [R1]
    @(posedge clk) disable iff (!rst_b)
    tick12 |-> ##12 tick12
  ) else $error("divide by 12 period wrong");
  slow_ticks_a: assert property ( // [R2]
    @(posedge clk) disable iff (!rst_b)
    tick192 |-> tick48 && tick12
  ) else $error("divide by 192 off the 48 grid");
  edge_detect_a: assert property ( // [R3]
    @(posedge clk) disable iff (!rst_b)
    pin_fall_s |=> pend0_r
  ) else $error("falling pin edge not pending");
  // a write or a gate at the counting tick would legally block it
  edge_count_a: assert property ( // [R4]
    @(posedge clk) disable iff (!rst_b)
    t1_fall_s ##0 next_tick_s ##0 (sel1 == 2'b01 && run1 && !wr
      && cfg1_r.mode == DTC_WIDE) |=> tl1 != $past(tl1)
  ) else $error("counted edge missing from count");
  run_hold_a: assert property ( // [R6]
    @(posedge clk) disable iff (!rst_b)
    !tr0_r && !wr |=> $stable(tl0)
  ) else $error("timer 0 moved while stopped");
  reload_value_a: assert property ( // [R8]
    @(posedge clk) disable iff (!rst_b)
    ovf0 && (cfg0_r.mode == DTC_RELOAD || cko0_en_r) && !wr
      |=> tl0 == $past(th0) && $stable(th0)
  ) else $error("reload did not copy high byte");
  hold_t1_a: assert property ( // [R9]
    @(posedge clk) disable iff (!rst_b)
    cfg1_r.mode == DTC_SPLIT && !cko1_en_r && !wr
      |=> $stable(tl1) && $stable(th1)
  ) else $error("timer 1 moved in mode 3");
  split_flag_a: assert property ( // [R11]
    @(posedge clk) disable iff (!rst_b)
    t0_split && ovf0_hi |=> tf1_r && irq1_r
  ) else $error("split high byte did not flag timer 1");
  cko_toggle_a: assert property ( // [R12]
    @(posedge clk) disable iff (!rst_b)
    ovf0 && cko0_en_r |=> p34_out != $past(p34_out)
  ) else $error("clock-out did not toggle");
  cko_no_irq_a: assert property ( // [R17]
    @(posedge clk) disable iff (!rst_b)
    ovf1 && cko1_en_r && !t0_split |=> !t1_irq && tf1_r
  ) else $error("clock-out raised an interrupt");
endmodule

// ---- rtl/dtc_consts.svh ----
/*
 * Constants of the dual timer/counter: register byte offsets, field
 * positions, reset values and prescaler counts.
 * Assumes a 10 MHz system clock and an APB register port.
 */
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

// register byte offsets
`define DTC_OFS_CTRL 8'h00
`define DTC_OFS_MODE 8'h04
`define DTC_OFS_T0LO 8'h08
`define DTC_OFS_T1LO 8'h0c
`define DTC_OFS_T0HI 8'h10
`define DTC_OFS_T1HI 8'h14
`define DTC_OFS_AUX 8'h18

// control register fields
`define DTC_CTRL_TF1 7
`define DTC_CTRL_TR1 6
`define DTC_CTRL_TF0 5
`define DTC_CTRL_TR0 4

// auxiliary register fields
`define DTC_AUX_TIMER0_EXTRA_PRESCALE 4
`define DTC_AUX_TIMER1_FAST_CLOCK_SELECT 3
`define DTC_AUX_TIMER0_FAST_CLOCK_SELECT 2
`define DTC_AUX_T1CKOE 1
`define DTC_AUX_T0CKOE 0

// reset value of every register
`define DTC_RST_BYTE 8'h00

// prescaler: base divide by 12, then by 4 and 16 more
`define DTC_DIV_BASE 12
`define DTC_DIV12_LAST 4'hb
`define DTC_DIV48_LAST 2'h3
`define DTC_DIV192_LAST 4'hf

`endif

// ---- rtl/dtc_pkg.sv ----
/*
 * Types of the dual timer/counter.
 * Assumes nothing beyond the constants header.
 */
package dtc_pkg;
  // operating mode field
  typedef enum logic [1:0] {
    DTC_PWM = 2'b00,
    DTC_WIDE = 2'b01,
    DTC_RELOAD = 2'b10,
    DTC_SPLIT = 2'b11
  } dtc_mode_t;

  // per-timer mode byte half
  typedef struct packed {
    logic gate;
    logic ct;
    dtc_mode_t mode;
  } dtc_cfg_t;
endpackage

// ---- verif/dtc_pin_model.sv ----
/*
 * Pin-side partner of the timers: count pin edges and the slow-oscillator
 * and watchdog source pulses.
 * Assumes clk and rst_b shared with the timers.
 */
module dtc_pin_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pins toward the timers
  output logic t0_pin,
  output logic t1_pin,
  output logic ilrc_tick,
  output logic wdt_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] ilrc_cnt_r;
  logic [2:0] wdt_cnt_r;

  initial begin
    t0_pin = 1'b1;
    t1_pin = 1'b1;
  end

  // one pulse every 7 and every 5 clocks
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ilrc_cnt_r <= 3'h0;
      wdt_cnt_r <= 3'h0;
    end else begin
      ilrc_cnt_r <= (ilrc_cnt_r == 3'h6) ? 3'h0 : ilrc_cnt_r + 3'h1;
      wdt_cnt_r <= (wdt_cnt_r == 3'h4) ? 3'h0 : wdt_cnt_r + 3'h1;
    end
  end
  assign ilrc_tick = (ilrc_cnt_r == 3'h6);
  assign wdt_tick = (wdt_cnt_r == 3'h4);

  // levels held 30 clocks, longer than two sample ticks; both pins
  // move together so each edge detector sees the same edges
  task edges(input int n);
    repeat (n) begin
      repeat (30) @(posedge clk);
      t0_pin <= 1'b0;
      t1_pin <= 1'b0;
      repeat (30) @(posedge clk);
      t0_pin <= 1'b1;
      t1_pin <= 1'b1;
    end
    repeat (30) @(posedge clk);
  endtask
endmodule

// ---- verif/dtc_timers_tb_top.sv ----
/*
 * Self-checking bench of the dual timer: APB master, read results queued
 * and compared by a monitor, event spacing measured on the pins.
 * Assumes the pin model partner and a 100 ns clock.
 */
module dtc_timers_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic t0_pin, t1_pin, ext_int0, ext_int1, ilrc_tick, wdt_tick;
  logic t0_irq, t1_irq, t1_baud_tick, p34_out, p34_drive;
  logic p35_out, p35_drive, pwm0_out, pwm1_out;
  logic [32:0] exq[$];
  int failures = 0, check_count = 0, seed = 33945, irq_seen = 0;
  int n, k, m;
  logic [7:0] r;
  // mode, aux, reload per row; expected irq spacing beside it
  localparam logic [23:0] TBL[7] = '{24'h000400, 24'h0204f0,
    24'h0604fe, 24'h0610fe, 24'h0210ff, 24'h0214ff, 24'h0200ff};
  localparam int GP[7] = '{256, 16, 14, 10, 48, 192, 12};
  localparam int K0[4] = '{12, 1, 48, 192};

  dtc_timers dut_u (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .t0_pin(t0_pin), .t1_pin(t1_pin), .ext_int0(ext_int0),
    .ext_int1(ext_int1), .ilrc_tick(ilrc_tick), .wdt_tick(wdt_tick),
    .t0_irq(t0_irq), .t1_irq(t1_irq), .t1_baud_tick(t1_baud_tick),
    .p34_out(p34_out), .p34_drive(p34_drive), .p35_out(p35_out),
    .p35_drive(p35_drive), .pwm0_out(pwm0_out), .pwm1_out(pwm1_out));
  dtc_pin_model pm_u (.clk(clk), .rst_b(rst_b), .t0_pin(t0_pin),
    .t1_pin(t1_pin), .ilrc_tick(ilrc_tick), .wdt_tick(wdt_tick));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task wrap_up;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // read results taken at the completing edge, oldest note first
  always @(posedge clk) begin
    if (t0_irq === 1'b1 || t1_irq === 1'b1)
      irq_seen++;
    if (psel && penable && pready === 1'b1) begin
      if (exq.size() == 0)
        chk({pslverr, prdata}, 33'h1ffffffff);
      else
        chk({pslverr, prdata}, exq.pop_front());
    end
  end

  task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    int c;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    c = 0;
    // request held until pready is seen high at a rising edge
    do begin
      @(posedge clk);
      c++;
    end while (pready !== 1'b1 && c < 20);
    if (pready !== 1'b1) begin
      failures++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // a write answers with zero data, and an error when unmapped
  task wr(input logic [7:0] a, input logic [7:0] d);
    exq.push_back({a > 8'h18, 32'h0});
    bus(a, 1'b1, d);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] d, input logic e);
    exq.push_back({e, 24'h0, d});
    bus(a, 1'b0, 8'h00);
  endtask

  function automatic logic sg(input int s);
    case (s)
      0: return p34_out;
      1: return p35_out;
      2: return t1_baud_tick;
      3: return t0_irq;
      default: return t1_irq;
    endcase
  endfunction

  // clocks between two successive events of one output
  task gap(input int s, output int g);
    int c, e;
    logic p, v;
    e = 0;
    g = 0;
    p = sg(s);
    for (c = 0; c < 20000 && e < 2; c++) begin
      @(negedge clk);
      v = sg(s);
      g++;
      if (s < 2 ? v !== p : (v === 1'b1 && p !== 1'b1)) begin
        e++;
        if (e == 1)
          g = 0;
      end
      p = v;
    end
    if (e < 2) begin
      failures++;
      wrap_up();
    end
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ext_int0 = 1'b1;
    ext_int1 = 1'b1;
    rst_b = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (k = 0; k < 8; k++)
      rd(8'(k * 4), 8'h00, k == 7);
    wr(8'h1c, 8'h55);
    // irq spacing per mode and source, reload byte untouched
    for (k = 0; k < 7; k++) begin
      wr(8'h00, 8'h00);
      wr(8'h04, TBL[k][23:16]);
      wr(8'h18, TBL[k][15:8]);
      wr(8'h10, TBL[k][7:0]);
      wr(8'h08, TBL[k][7:0]);
      wr(8'h00, 8'h10);
      gap(3, n);
      chk(33'(n), 33'(GP[k]));
      rd(8'h10, TBL[k][7:0], 1'b0);
    end
    // pwm duty over one full wrap of both low bytes
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h18, 8'h0c);
    wr(8'h10, 8'h40);
    wr(8'h14, 8'h80);
    wr(8'h00, 8'h50);
    n = 0;
    m = 0;
    repeat (4) @(posedge clk);
    repeat (256) begin
      @(negedge clk);
      n += (pwm0_out === 1'b1);
      m += (pwm1_out === 1'b1);
    end
    chk(33'(n), 33'd64);
    chk(33'(m), 33'd128);
    // clock-out on both timers: stop, clear C/T, set source and enable, load bytes, then run
    for (k = 0; k < 6; k++) begin
      // even reloads only: two counts at least, so baud ticks stay pulses
      r = 8'hf8 | 8'($random(seed) & 6);
      m = (k < 4) ? 8'h10 : 8'h40;
      // second write clears a flag set on the edge that stops a timer
      repeat (2) wr(8'h00, 8'h00);
      wr(8'h04, 8'h00);
      wr(8'h18, (k < 4) ? 8'((k[1] << 4) | (k[0] << 2) | 1) :
        8'(((k - 4) << 3) | 2));
      wr((k < 4) ? 8'h10 : 8'h14, r);
      wr((k < 4) ? 8'h08 : 8'h0c, r);
      irq_seen = 0;
      wr(8'h00, 8'(m));
      gap(k < 4 ? 0 : 1, n);
      chk(33'(n), 33'(((k < 4) ? K0[k] : K0[k - 4]) * (256 - r)));
      chk({32'h0, k < 4 ? p34_drive : p35_drive}, 33'h1);
      if (k >= 4) begin
        gap(2, n);
        chk(33'(n), 33'(K0[k - 4] * (256 - r)));
      end
      chk(33'(irq_seen), 33'h0);
      rd(8'h00, 8'(m * 3), 1'b0);
    end
    // event counting on timer 1 pin, 16-bit carry, then gated off
    n = 1 + ($random(seed) & 3);
    wr(8'h00, 8'h00);
    wr(8'h18, 8'h00);
    wr(8'h04, 8'h50);
    wr(8'h0c, 8'hff);
    wr(8'h14, 8'h00);
    wr(8'h00, 8'h40);
    pm_u.edges(n);
    rd(8'h0c, 8'(n - 1), 1'b0);
    rd(8'h14, 8'h01, 1'b0);
    wr(8'h04, 8'hd0);
    ext_int1 <= 1'b0;
    pm_u.edges(2);
    rd(8'h0c, 8'(n - 1), 1'b0);
    // timer 1 mode 3 holds its count
    wr(8'h18, 8'h08);
    wr(8'h04, 8'h30);
    repeat (100) @(posedge clk);
    rd(8'h0c, 8'(n - 1), 1'b0);
    // timer 0 split: high byte runs on timer 1 run bit and flag
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h03);
    wr(8'h18, 8'h04);
    wr(8'h08, 8'h00);
    wr(8'h10, 8'hf0);
    wr(8'h00, 8'h40);
    gap(4, n);
    chk(33'(n), 33'd256);
    rd(8'h08, 8'h00, 1'b0);
    rd(8'h00, 8'hc0, 1'b0);
    repeat (4) @(posedge clk);
    wrap_up();
  end
endmodule
